// *** hdl/sub_swap_defs.vh ***
// Constants for the subtract and nibble exchange execution block.
// Assumes inclusion by bare name from hdl/ design files.
`ifndef SUB_SWAP_DEFS_VH
`define SUB_SWAP_DEFS_VH

// ****************************************************************
// Instruction decode
// ****************************************************************
`define OPC_MSB         11
`define OPC_LSB         6
`define OPC_SUB         6'h02
`define OPC_SWAP        6'h0e
`define DEST_BIT        5
`define ADDR_MSB        4
`define ADDR_LSB        0
`define INSTR_MSB       11
`define INSTR_LSB       0
`define FIDX_MSB        6
`define FIDX_LSB        2

// ****************************************************************
// Data and status
// ****************************************************************
`define NIB_HI_MSB      7
`define NIB_HI_LSB      4
`define NIB_LO_MSB      3
`define NIB_LO_LSB      0
`define ACC_RST         8'h00
`define FILE_RST        8'h00
`define FLAG_RST        1'h0
`define APB_SLVERR      1'h0

// ****************************************************************
// APB register map (byte addresses)
// ****************************************************************
`define ADDR_INSTR      12'h000
`define ADDR_ACC        12'h004
`define ADDR_STATUS     12'h008
`define ADDR_FILE_BASE  12'h080
`define ADDR_FILE_END   12'h0fc
`define INSTR_RST       12'h000
`define ST_CARRY        0
`define ST_HALF         1
`define ST_ZERO         2

`endif

// *** hdl/sub_swap_alu.v ***
// Combinational arithmetic for subtract and nibble exchange.
// Assumes operands come from registers on the same clock.
`timescale 1ns/100ps
`include "sub_swap_defs.vh"

module sub_swap_alu #(
   parameter W = 8
) (
   // Operands
   input  wire [W-1:0] file_val_i,
   input  wire [W-1:0] acc_val_i,
   // Results
   output wire [W-1:0] diff_o,
   output wire [W-1:0] swap_o,
   output wire         carry_o,
   output wire         half_carry_bit_o,
   output wire         zero_o
);

   wire [W:0] full_sum;
   wire [4:0] low_sum;

   // Two's complement: f + ~w + 1; carry out set means no borrow.
   assign full_sum         = {1'b0, file_val_i} + {1'b0, ~acc_val_i} + {{W{1'b0}}, 1'b1};
   assign diff_o           = full_sum[W-1:0];
   assign carry_o          = full_sum[W];
   assign low_sum          = {1'b0, file_val_i[`NIB_LO_MSB:`NIB_LO_LSB]}
                             + {1'b0, ~acc_val_i[`NIB_LO_MSB:`NIB_LO_LSB]} + 5'h01;
   assign half_carry_bit_o = low_sum[4];
   assign zero_o           = (full_sum[W-1:0] == {W{1'b0}});
   assign swap_o           = {file_val_i[`NIB_LO_MSB:`NIB_LO_LSB],
                              file_val_i[`NIB_HI_MSB:`NIB_HI_LSB]};

endmodule

// *** hdl/sub_swap_core.v ***
// Executes the subtract and nibble exchange instructions of an 8-bit core.
// Assumes an APB master on core_clk_i; instruction, working register,
// status and 32 file registers are all reachable over APB.
`timescale 1ns/100ps
`include "sub_swap_defs.vh"

// Operation
// - Subtract working register from file register.
// - Subtract result to acc or file by d.
// - Carry set when no borrow, else cleared.
// - Nibble exchange swaps upper and lower halves.
// - Exchange result to acc or file by d.
// - File address from low five instruction bits.
module sub_swap_core #(
   parameter W     = 8,
   parameter NFILE = 32
) (
   // Clock and reset
   input  wire        core_clk_i,
   input  wire        nrst_i,
   // APB slave
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output reg         pready_o,
   output reg         pslverr_o,
   // Status flags
   output reg         carry_o,
   output reg         half_carry_bit_o,
   output reg         zero_o,
   // Execution pulse
   output reg         exec_done_o
);

   // ****************************************************************
   // State
   // ****************************************************************
   reg  [W-1:0]  file_ff [0:NFILE-1];
   reg  [W-1:0]  acc_ff;
   reg  [11:0]   instr_ff;
   reg           exec_ff;
   reg           carry_ff;
   reg           half_ff;
   reg           zero_ff;

   wire [5:0]    opcode;
   wire          dest;
   wire [4:0]    faddr;
   wire          is_sub;
   wire          is_swap;
   wire [W-1:0]  fval;
   wire [W-1:0]  diff;
   wire [W-1:0]  swapped;
   wire          alu_c;
   wire          alu_dc;
   wire          alu_z;
   wire [W-1:0]  result;
   wire          setup;
   wire          wr_acc;
   wire          rd_ok;
   wire [31:0]   nxt_prdata;
   integer       i;
   wire          wr_instr;
   wire          wr_status;
   wire          wr_file;
   wire [4:0]    fidx;
   wire          exec_acc;
   wire          exec_file;
   reg  [W-1:0]  nxt_acc;
   reg           nxt_carry;
   reg           nxt_half;
   reg           nxt_zero;
   reg           file_we;
   reg  [4:0]    file_wa;
   reg  [W-1:0]  file_wd;

   // ****************************************************************
   // Decode
   // ****************************************************************
   assign opcode  = instr_ff[`OPC_MSB:`OPC_LSB];
   assign dest    = instr_ff[`DEST_BIT];
   assign faddr   = instr_ff[`ADDR_MSB:`ADDR_LSB];
   assign is_sub  = exec_ff && (opcode == `OPC_SUB);
   assign is_swap = exec_ff && (opcode == `OPC_SWAP);
   assign fval    = file_ff[faddr];
   assign result  = is_sub ? diff : swapped;
   // Only the two decoded instructions write a destination.
   assign exec_acc  = (is_sub || is_swap) && !dest;
   assign exec_file = (is_sub || is_swap) && dest;

   sub_swap_alu #(
      .W                (W)
   ) u_alu (
      .file_val_i       (fval),
      .acc_val_i        (acc_ff),
      .diff_o           (diff),
      .swap_o           (swapped),
      .carry_o          (alu_c),
      .half_carry_bit_o (alu_dc),
      .zero_o           (alu_z)
   );

   // ****************************************************************
   // APB decode
   // ****************************************************************
   function is_file_addr;
      input [11:0] a;
      begin
         is_file_addr = (a >= `ADDR_FILE_BASE) && (a <= `ADDR_FILE_END);
      end
   endfunction

   // Setup cycle acts; access cycle completes with pready already high.
   assign setup  = psel_i && !penable_i;
   assign wr_acc = setup && pwrite_i && (paddr_i == `ADDR_ACC);
   assign rd_ok  = setup && !pwrite_i;
   assign wr_instr  = setup && pwrite_i && (paddr_i == `ADDR_INSTR);
   assign wr_status = setup && pwrite_i && (paddr_i == `ADDR_STATUS);
   assign wr_file   = setup && pwrite_i && is_file_addr(paddr_i);
   assign fidx      = paddr_i[`FIDX_MSB:`FIDX_LSB];

   // ****************************************************************
   // Read data selection
   // ****************************************************************
   // Unmapped addresses read as zero.
   function [31:0] read_word;
      input [11:0]  a;
      input [11:0]  ins;
      input [W-1:0] acc;
      input [2:0]   st;
      input [W-1:0] fw;
      begin
         case (a)
            `ADDR_INSTR: begin
               read_word = {20'h00000, ins};
            end
            `ADDR_ACC: begin
               read_word = {{(32-W){1'b0}}, acc};
            end
            `ADDR_STATUS: begin
               read_word = {29'h00000000, st};
            end
            default: begin
               if (is_file_addr(a)) begin
                  read_word = {{(32-W){1'b0}}, fw};
               end else begin
                  read_word = 32'h00000000;
               end
            end
         endcase
      end
   endfunction

   assign nxt_prdata = read_word(paddr_i, instr_ff, acc_ff, {zero_ff, half_ff, carry_ff},
                                 file_ff[fidx]);

   // ****************************************************************
   // APB response
   // ****************************************************************
   // Only the setup cycle acts, so the access phase never waits.
   always @(posedge core_clk_i) begin
      if (!nrst_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h00000000;
      end else begin
         pready_o  <= setup;
         pslverr_o <= `APB_SLVERR;
         if (rd_ok) begin
            prdata_o <= nxt_prdata;
         end
      end
   end

   // ****************************************************************
   // Instruction launch
   // ****************************************************************
   // A written instruction executes in the following cycle, which is
   // the access phase, so it never meets another software write.
   always @(posedge core_clk_i) begin
      if (!nrst_i) begin
         instr_ff    <= `INSTR_RST;
         exec_ff     <= 1'b0;
         exec_done_o <= 1'b0;
      end else begin
         exec_ff     <= wr_instr;
         exec_done_o <= exec_ff;
         if (wr_instr) begin
            instr_ff <= pwdata_i[`INSTR_MSB:`INSTR_LSB];
         end
      end
   end

   // ****************************************************************
   // Next values of working register, file write and status
   // ****************************************************************
   // Execution takes priority over a same-cycle software write to its
   // target; that software write is then lost.
   always @* begin
      nxt_acc   = acc_ff;
      nxt_carry = carry_ff;
      nxt_half  = half_ff;
      nxt_zero  = zero_ff;
      file_we   = 1'b0;
      file_wa   = fidx;
      file_wd   = pwdata_i[W-1:0];
      if (exec_acc) begin
         nxt_acc = result;
      end else if (wr_acc) begin
         nxt_acc = pwdata_i[W-1:0];
      end
      if (exec_file) begin
         file_we = 1'b1;
         file_wa = faddr;
         file_wd = result;
      end else if (wr_file) begin
         file_we = 1'b1;
      end
      // Exchange leaves the flags alone; subtract updates all three.
      if (is_sub) begin
         nxt_carry = alu_c;
         nxt_half  = alu_dc;
         nxt_zero  = alu_z;
      end else if (wr_status) begin
         nxt_carry = pwdata_i[`ST_CARRY];
         nxt_half  = pwdata_i[`ST_HALF];
         nxt_zero  = pwdata_i[`ST_ZERO];
      end
   end

   // ****************************************************************
   // Working register and status
   // ****************************************************************
   always @(posedge core_clk_i) begin
      if (!nrst_i) begin
         acc_ff   <= `ACC_RST;
         carry_ff <= `FLAG_RST;
         half_ff  <= `FLAG_RST;
         zero_ff  <= `FLAG_RST;
      end else begin
         acc_ff   <= nxt_acc;
         carry_ff <= nxt_carry;
         half_ff  <= nxt_half;
         zero_ff  <= nxt_zero;
      end
   end

   // ****************************************************************
   // File registers
   // ****************************************************************
   always @(posedge core_clk_i) begin
      if (!nrst_i) begin
         for (i = 0; i < NFILE; i = i + 1) begin
            file_ff[i] <= `FILE_RST;
         end
      end else if (file_we) begin
         file_ff[file_wa] <= file_wd;
      end
   end

   // ****************************************************************
   // Status flag outputs
   // ****************************************************************
   // The flag pins take the same value as the status register at the
   // same edge, so a software write and a subtract show alike.
   always @(posedge core_clk_i) begin
      if (!nrst_i) begin
         carry_o          <= 1'b0;
         half_carry_bit_o <= 1'b0;
         zero_o           <= 1'b0;
      end else begin
         carry_o          <= nxt_carry;
         half_carry_bit_o <= nxt_half;
         zero_o           <= nxt_zero;
      end
   end

endmodule

// *** bench/sub_swap_chk.sv ***
// Port assertions for the subtract and nibble exchange core.
// Assumes an APB master on core_clk_i and one instruction at a time.
`timescale 1ns/100ps
`include "sub_swap_defs.vh"
module sub_swap_chk #(
   parameter W     = 8,
   parameter NFILE = 32
) (
   // Clock, reset and APB requests
   input wire        core_clk_i,
   input wire        nrst_i,
   input wire        psel_i,
   input wire        penable_i,
   input wire        pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   // Design outputs
   input wire [31:0] prdata_o,
   input wire        pready_o,
   input wire        pslverr_o,
   input wire        carry_o,
   input wire        half_carry_bit_o,
   input wire        zero_o,
   input wire        exec_done_o
);
   wire setup  = psel_i && !penable_i;
   wire ins_wr = setup && pwrite_i && paddr_i == `ADDR_INSTR;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   ready_after_setup_a: assert property (setup |=> pready_o ##1 !pready_o)
      else $error("ready not a single cycle after setup");
   ready_cause_a: assert property (pready_o |-> $past(setup))
      else $error("ready without setup");
   no_error_a: assert property (pslverr_o == 1'b0)
      else $error("error response raised");
   exec_pulse_a: assert property (ins_wr |-> ##[1:2] exec_done_o)
      else $error("no execution pulse");
   pulse_single_a: assert property (exec_done_o |=> !exec_done_o)
      else $error("execution pulse too long");
   sub_zero_flags_a: assert property (ins_wr && pwdata_i[11:6] == `OPC_SUB
      |-> ##2 (!zero_o || carry_o && half_carry_bit_o))
      else $error("zero result with borrow");
   swap_flags_kept_a: assert property (ins_wr && pwdata_i[11:6] == `OPC_SWAP
      |-> ##2 $stable({carry_o, half_carry_bit_o, zero_o}))
      else $error("exchange changed flags");
   status_mirror_a: assert property (setup && !pwrite_i && paddr_i == `ADDR_STATUS
      |=> prdata_o[2:0] == $past({zero_o, half_carry_bit_o, carry_o}))
      else $error("status read differs from flags");
endmodule
bind sub_swap_core sub_swap_chk #(.W(W), .NFILE(NFILE)) u_chk (.*);

// *** bench/tb.sv ***
// Self-checking bench for the subtract and nibble exchange core.
// Assumes the core and its checker are compiled before this file.
`timescale 1ns/100ps
`include "sub_swap_defs.vh"
module tb;
   reg         core_clk_i = 0, nrst_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
   reg  [11:0] paddr_i = 0;
   reg  [31:0] pwdata_i = 0;
   wire [31:0] prdata_o;
   wire        pready_o, pslverr_o, carry_o, half_carry_bit_o, zero_o, exec_done_o;
   integer     mismatches = 0, total_checks = 0;
   logic [31:0] rd;
   always #5 core_clk_i = ~core_clk_i;
   sub_swap_core DUT (.*);
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] wd, output [31:0] r);
      integer n;
      begin
         @(posedge core_clk_i);
         psel_i <= 1;
         pwrite_i <= w;
         paddr_i <= a;
         pwdata_i <= wd;
         @(posedge core_clk_i);
         penable_i <= 1;
         n = 0;
         @(negedge core_clk_i);
         while (pready_o !== 1'b1 && n < 16) begin
            @(negedge core_clk_i);
            n++;
         end
         if (n >= 16) begin
            mismatches++;
            $display("MISMATCH %0t no ready from slave", $time);
            tally_and_finish;
         end
         r = prdata_o;
         @(posedge core_clk_i);
         psel_i <= 0;
         penable_i <= 0;
      end
   endtask
   // Loads operands and a known status, executes, then reads back working register, file register and status.
   task op(input [5:0] opc, input d, input [4:0] fa, input [7:0] fv, input [7:0] wv);
      logic [7:0] r;
      logic [2:0] st;
      begin
         apb(1, `ADDR_FILE_BASE | {fa, 2'b00}, fv, rd);
         apb(1, `ADDR_ACC, wv, rd);
         apb(1, `ADDR_STATUS, 3'h5, rd);
         apb(1, `ADDR_INSTR, {opc, d, fa}, rd);
         r = opc == `OPC_SUB ? fv - wv : opc == `OPC_SWAP ? {fv[3:0], fv[7:4]} : (d ? fv : wv);
         st = opc == `OPC_SUB ? {r == 0, fv[3:0] >= wv[3:0], fv >= wv} : 3'h5;
         apb(0, `ADDR_ACC, 0, rd);
         chk(rd, d ? wv : r);
         apb(0, `ADDR_FILE_BASE | {fa, 2'b00}, 0, rd);
         chk(rd, d ? r : fv);
         apb(0, `ADDR_STATUS, 0, rd);
         chk(rd, st);
         chk({zero_o, half_carry_bit_o, carry_o}, st);
         $display("test done: op %h dest %b file %0d", opc, d, fa);
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", total_checks, mismatches);
         if (mismatches == 0 && total_checks > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   initial begin
      repeat (6) @(posedge core_clk_i);
      nrst_i <= 1;
      apb(0, `ADDR_ACC, 0, rd);
      chk(rd, 0);
      apb(1, 12'h00c, 32'hff, rd);
      apb(0, 12'h00c, 0, rd);
      chk(rd, 0);
      $display("test done: reset and unmapped");
      op(`OPC_SUB, 1, 1, 8'h03, 8'h02);
      op(`OPC_SUB, 0, 31, 8'h02, 8'h02);
      op(`OPC_SUB, 0, 0, 8'h01, 8'h02);
      op(`OPC_SUB, 1, 16, 8'h10, 8'h01);
      op(`OPC_SWAP, 0, 5, 8'ha5, 8'h00);
      op(`OPC_SWAP, 1, 10, 8'h3c, 8'h77);
      op(6'h06, 1, 7, 8'h3c, 8'h77);
      tally_and_finish;
   end
   initial begin
      #20000;
      mismatches++;
      tally_and_finish;
   end
endmodule
